// ### rtl/ddspa_pkg.sv
// Shared constants, control carriers and state codes for the profile,
// phase and amplitude control block.
// Assumes a single 40 MHz system clock and a synchronous active-high reset.
package ddspa_pkg;

   // Clock and divided-clock timing.
   localparam int DDSPA_CLK_PERIOD_NS = 25;
   localparam int DDSPA_SYNC_PERIOD_NS = 100;
   localparam int DDSPA_DIV_RATIO = DDSPA_SYNC_PERIOD_NS / DDSPA_CLK_PERIOD_NS;
   localparam logic [1:0] DDSPA_DIV_RESET = 2'h0;
   localparam logic [1:0] DDSPA_DIV_RISE = 2'h1;

   // Sequencing field codes.
   localparam logic [2:0] DDSPA_SEQ_OFF = 3'h0;
   localparam logic [2:0] DDSPA_SEQ_BAD = 3'h7;
   localparam int DDSPA_SEQ_LOOP_BIT = 2;
   localparam logic [1:0] DDSPA_PROFILE_FIRST = 2'h0;
   localparam logic [2:0] DDSPA_RAM_RAMP_UP = 3'h1;

   // Keying timer and counter.
   localparam logic [7:0] DDSPA_TIMER_END = 8'h01;
   localparam logic [7:0] DDSPA_TIMER_RESET = 8'h00;
   localparam logic [13:0] DDSPA_SCALE_RESET = 14'h0000;
   localparam int DDSPA_STEP_MSB = 15;
   localparam int DDSPA_STEP_LSB = 14;
   localparam logic [31:0] DDSPA_ACC_RESET = 32'h00000000;
   localparam logic [3:0] DDSPA_SYNC_RESET = 4'h0;

   typedef struct packed {
      logic [2:0] seq_mode;
      logic load_keying_timer;
      logic keying_enable;
      logic internal_keying;
      logic auto_clear;
      logic continuous_clear;
   } ddspa_ctrl_t;

   typedef struct packed {
      logic [15:0] amplitude_limit_word;
      logic [7:0] amplitude_ramp_rate;
      logic [13:0] amplitude_scale_register;
   } ddspa_amp_t;

   localparam ddspa_ctrl_t DDSPA_CTRL_RESET = 8'h00;
   localparam ddspa_amp_t DDSPA_AMP_RESET = 38'h0000000000;

   typedef enum logic [2:0] {
      DDSPA_ST_IDLE = 3'h1,
      DDSPA_ST_RUN = 3'h2,
      DDSPA_ST_DONE = 3'h4
   } ddspa_seq_state_t;

endpackage : ddspa_pkg

// ### rtl/ddspa_keying.sv
// Amplitude keying unit: ramp timer, scale factor counter and output multiplier.
// Assumes the keying pin level arrives already synchronised and that the
// settings only change on the transfer pulse from the parent.
`timescale 1ns/1ps
module ddspa_keying import ddspa_pkg::*; #(
   parameter int SCALE_W = 14
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic keying_enable_i,
   input wire logic internal_keying_i,
   input wire logic load_keying_timer_i,
   input wire logic transfer_i,
   input wire logic keying_input_pin_i,
   input wire ddspa_amp_t amp_i,
   input wire logic [SCALE_W-1:0] sample_i,
   output logic [SCALE_W-1:0] scale_factor_o,
   output logic [SCALE_W-1:0] sample_o
);
   logic [7:0] timer_reg;
   logic [SCALE_W-1:0] count_reg;
   logic auto_prev_reg;
   logic pin_prev_reg;
   logic [SCALE_W-1:0] sample_reg;

   wire auto_w = keying_enable_i & internal_keying_i;
   wire pin_edge_w = keying_input_pin_i ^ pin_prev_reg;
   wire timer_hit_w = timer_reg <= DDSPA_TIMER_END;
   wire reload_w = (auto_w & ~auto_prev_reg) | pin_edge_w | (load_keying_timer_i & transfer_i) | timer_hit_w;
   wire step_w = auto_w & timer_hit_w;
   wire [SCALE_W:0] step_size_w = (SCALE_W+1)'(1) << amp_i.amplitude_limit_word[DDSPA_STEP_MSB:DDSPA_STEP_LSB];
   wire [SCALE_W:0] limit_w = {1'b0, amp_i.amplitude_limit_word[SCALE_W-1:0]};
   wire [SCALE_W:0] up_sum_w = {1'b0, count_reg} + step_size_w;
   wire [SCALE_W-1:0] count_up_w = (up_sum_w > limit_w) ? limit_w[SCALE_W-1:0] : up_sum_w[SCALE_W-1:0];
   wire [SCALE_W-1:0] count_dn_w = ({1'b0, count_reg} < step_size_w) ? '0 : count_reg - step_size_w[SCALE_W-1:0];
   wire [SCALE_W-1:0] count_next = step_w ? (keying_input_pin_i ? count_up_w : count_dn_w) : count_reg;
   wire [SCALE_W-1:0] scale_w = auto_w ? count_reg : amp_i.amplitude_scale_register;
   wire [2*SCALE_W-1:0] product_w = sample_i * scale_w;
   wire [SCALE_W-1:0] sample_next = keying_enable_i ? product_w[2*SCALE_W-1:SCALE_W] : sample_i;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         timer_reg <= DDSPA_TIMER_RESET;
         count_reg <= DDSPA_SCALE_RESET;
         auto_prev_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
         sample_reg <= '0;
      end else begin
         timer_reg <= (reload_w | ~auto_w) ? amp_i.amplitude_ramp_rate : timer_reg - 8'h01;
         count_reg <= count_next;
         auto_prev_reg <= auto_w;
         pin_prev_reg <= keying_input_pin_i;
         sample_reg <= sample_next;
      end
   end

   assign scale_factor_o = scale_w;
   assign sample_o = sample_reg;

   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);

   chk_pin_reload: assert property (auto_w && pin_edge_w |=> timer_reg == $past(amp_i.amplitude_ramp_rate))
      else $error("Timer not reloaded on keying pin change.");
   chk_auto_start: assert property (auto_w && !auto_prev_reg |=> timer_reg == $past(amp_i.amplitude_ramp_rate))
      else $error("Timer not reloaded when automatic keying starts.");
   chk_strobe_reload: assert property (auto_w && load_keying_timer_i && transfer_i
      |=> timer_reg == $past(amp_i.amplitude_ramp_rate))
      else $error("Timer not reloaded on strobe with load bit set.");
   chk_limit_cap: assert property (step_w && keying_input_pin_i |=> count_reg <= $past(limit_w))
      else $error("Scale factor ramped above the limit.");
   chk_floor_zero: assert property (step_w && !keying_input_pin_i && {1'b0, count_reg} <= step_size_w
      |=> count_reg == '0)
      else $error("Scale factor did not saturate at zero.");
   chk_bypass_path: assert property (!keying_enable_i |=> sample_o == $past(sample_i))
      else $error("Sample not bypassed while keying disabled.");
   cov_ramp_full: cover property (step_w && keying_input_pin_i ##1 count_reg == limit_w[SCALE_W-1:0]);
endmodule : ddspa_keying

// ### rtl/ddspa_ctrl.sv
// Control logic around a synthesis core: profile sequencer, phase accumulator
// with clear controls, update strobe synchroniser and amplitude keying.
// Assumes the strobe, keying and profile pins are asynchronous to clock_i and
// that the RAM address generator signals its final address for one cycle.
`timescale 1ns/1ps
module ddspa_ctrl import ddspa_pkg::*; #(
   parameter int SCALE_W = 14,
   parameter int PHASE_W = 14,
   parameter int ACC_W = 32
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic update_pin_i,
   input wire logic keying_input_pin_i,
   input wire logic [1:0] profile_pin_i,
   input wire ddspa_ctrl_t ctrl_i,
   input wire ddspa_amp_t amp_i,
   input wire logic [ACC_W-1:0] freq_word_i,
   input wire logic [PHASE_W-1:0] phase_offset_i,
   input wire logic ram_enable_i,
   input wire logic [2:0] ram_segment_mode_i,
   input wire logic ram_at_final_i,
   input wire logic [SCALE_W-1:0] core_sample_i,
   output logic sync_clk_o,
   output logic transfer_o,
   output logic [PHASE_W-1:0] phase_o,
   output logic [1:0] profile_o,
   output logic [2:0] segment_mode_o,
   output logic seq_engaged_o,
   output logic sweep_restart_o,
   output logic burst_done_o,
   output logic [SCALE_W-1:0] scale_factor_o,
   output logic [SCALE_W-1:0] amplitude_o
);

   // Pin synchronisers: bit 0 strobe, bit 1 keying pin, bits 3:2 profile pins.
   logic [3:0] pin_meta_reg;
   logic [3:0] pin_sync_reg;
   wire [3:0] pin_raw_w = {profile_pin_i, keying_input_pin_i, update_pin_i};

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pin_meta_reg <= DDSPA_SYNC_RESET;
         pin_sync_reg <= DDSPA_SYNC_RESET;
      end else begin
         pin_meta_reg <= pin_raw_w;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   wire update_sync_w = pin_sync_reg[0];
   wire keying_sync_w = pin_sync_reg[1];
   wire [1:0] profile_sync_w = pin_sync_reg[3:2];

   // Divided clock and strobe edge detection.
   logic [1:0] div_reg;
   logic sync_clk_reg;
   logic update_seen_reg;
   logic transfer_reg;

   wire [1:0] div_next = div_reg + 2'h1;
   wire sync_rise_w = div_reg == DDSPA_DIV_RISE;
   wire update_event_w = sync_rise_w & update_sync_w & ~update_seen_reg;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         div_reg <= DDSPA_DIV_RESET;
         sync_clk_reg <= 1'b0;
         update_seen_reg <= 1'b0;
         transfer_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         sync_clk_reg <= div_next[1];
         if (sync_rise_w) begin
            update_seen_reg <= update_sync_w;
         end
         transfer_reg <= update_event_w;
      end
   end

   // Buffered settings move to the active registers on the strobe; the
   // behaviour that reacts to the strobe acts one cycle later on the new values.
   ddspa_ctrl_t ctrl_reg;
   ddspa_amp_t amp_reg;
   logic [ACC_W-1:0] freq_reg;
   logic [PHASE_W-1:0] offset_reg;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ctrl_reg <= DDSPA_CTRL_RESET;
         amp_reg <= DDSPA_AMP_RESET;
         freq_reg <= '0;
         offset_reg <= '0;
      end else if (update_event_w) begin
         ctrl_reg <= ctrl_i;
         amp_reg <= amp_i;
         freq_reg <= freq_word_i;
         offset_reg <= phase_offset_i;
      end
   end

   // Phase accumulator.
   logic [ACC_W-1:0] acc_reg;
   logic [PHASE_W-1:0] phase_reg;

   wire acc_clear_w = ctrl_reg.continuous_clear | (ctrl_reg.auto_clear & transfer_reg);
   wire [ACC_W-1:0] acc_next = acc_clear_w ? DDSPA_ACC_RESET : acc_reg + freq_reg;
   wire [PHASE_W-1:0] phase_next = acc_reg[ACC_W-1:ACC_W-PHASE_W] + offset_reg;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         acc_reg <= DDSPA_ACC_RESET;
         phase_reg <= '0;
      end else begin
         acc_reg <= acc_next;
         phase_reg <= phase_next;
      end
   end

   // Profile sequencer.
   ddspa_seq_state_t state_reg;
   ddspa_seq_state_t state_next;
   logic [1:0] seq_prof_reg;
   logic [1:0] seq_prof_next;
   logic restart_next;
   logic restart_reg;
   logic [1:0] profile_reg;
   logic [2:0] segment_reg;

   wire [2:0] seq_code_w = ctrl_reg.seq_mode;
   wire engaged_w = ram_enable_i & (seq_code_w != DDSPA_SEQ_OFF) & (seq_code_w != DDSPA_SEQ_BAD);
   wire loop_w = seq_code_w[DDSPA_SEQ_LOOP_BIT];
   wire [1:0] last_prof_w = loop_w ? 2'(seq_code_w[1:0] + 2'h1) : seq_code_w[1:0];
   wire at_last_w = seq_prof_reg == last_prof_w;

   always_comb begin
      state_next = state_reg;
      seq_prof_next = seq_prof_reg;
      restart_next = 1'b0;
      if (!engaged_w) begin
         state_next = DDSPA_ST_IDLE;
         seq_prof_next = DDSPA_PROFILE_FIRST;
      end else if (transfer_reg) begin
         state_next = DDSPA_ST_RUN;
         seq_prof_next = DDSPA_PROFILE_FIRST;
         restart_next = 1'b1;
      end else begin
         case (state_reg)
            DDSPA_ST_RUN: begin
               if (ram_at_final_i) begin
                  restart_next = 1'b1;
                  if (!at_last_w) begin
                     seq_prof_next = 2'(seq_prof_reg + 2'h1);
                  end else if (loop_w) begin
                     seq_prof_next = DDSPA_PROFILE_FIRST;
                  end else begin
                     state_next = DDSPA_ST_DONE;
                     restart_next = 1'b0;
                  end
               end
            end
            DDSPA_ST_IDLE: begin
               state_next = DDSPA_ST_IDLE;
            end
            DDSPA_ST_DONE: begin
               state_next = DDSPA_ST_DONE;
            end
            default: begin
               state_next = DDSPA_ST_IDLE;
            end
         endcase
      end
   end

   wire [1:0] profile_next = engaged_w ? seq_prof_next : profile_sync_w;
   wire [2:0] segment_next = engaged_w ? DDSPA_RAM_RAMP_UP : ram_segment_mode_i;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_reg <= DDSPA_ST_IDLE;
         seq_prof_reg <= DDSPA_PROFILE_FIRST;
         restart_reg <= 1'b0;
         profile_reg <= DDSPA_PROFILE_FIRST;
         segment_reg <= DDSPA_SEQ_OFF;
      end else begin
         state_reg <= state_next;
         seq_prof_reg <= seq_prof_next;
         restart_reg <= restart_next;
         profile_reg <= profile_next;
         segment_reg <= segment_next;
      end
   end

   // Amplitude keying.
   ddspa_keying #(
      .SCALE_W(SCALE_W)
   ) u_keying (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .keying_enable_i(ctrl_reg.keying_enable),
      .internal_keying_i(ctrl_reg.internal_keying),
      .load_keying_timer_i(ctrl_reg.load_keying_timer),
      .transfer_i(transfer_reg),
      .keying_input_pin_i(keying_sync_w),
      .amp_i(amp_reg),
      .sample_i(core_sample_i),
      .scale_factor_o(scale_factor_o),
      .sample_o(amplitude_o)
   );

   assign sync_clk_o = sync_clk_reg;
   assign transfer_o = transfer_reg;
   assign phase_o = phase_reg;
   assign profile_o = profile_reg;
   assign segment_mode_o = segment_reg;
   assign seq_engaged_o = engaged_w;
   assign sweep_restart_o = restart_reg;
   assign burst_done_o = state_reg == DDSPA_ST_DONE;

   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);

   chk_sync_period: assert property ($rose(sync_clk_o) |=> !$rose(sync_clk_o) [*3] ##1 $rose(sync_clk_o))
      else $error("Divided clock period is not four cycles.");
   chk_update_single: assert property (transfer_o |=> !transfer_o [*3])
      else $error("Strobe produced more than one transfer.");
   chk_update_edge: assert property (transfer_o |-> $past(update_seen_reg, 2) == 1'b0)
      else $error("Transfer without a low strobe sample before.");
   chk_clear_hold: assert property (ctrl_reg.continuous_clear |=> acc_reg == '0)
      else $error("Accumulator not held at zero.");
   chk_auto_clear: assert property (transfer_o && ctrl_reg.auto_clear |=> acc_reg == '0)
      else $error("Accumulator not cleared on strobe.");
   chk_phase_sum: assert property (##1 phase_o == 14'($past(acc_reg[ACC_W-1:ACC_W-PHASE_W]) + $past(offset_reg)))
      else $error("Phase output is not accumulator plus offset.");
   chk_seq_start: assert property (engaged_w && transfer_o |=> state_reg == DDSPA_ST_RUN && seq_prof_reg == 2'h0)
      else $error("Burst did not start at profile zero.");
   chk_seq_hold: assert property (engaged_w && !transfer_o && !ram_at_final_i |=> $stable(seq_prof_reg))
      else $error("Profile changed before final address.");
   chk_seq_wrap: assert property (engaged_w && !transfer_o && state_reg == DDSPA_ST_RUN && ram_at_final_i
      && at_last_w && loop_w |=> seq_prof_reg == 2'h0 && state_reg == DDSPA_ST_RUN)
      else $error("Continuous sequence did not restart at zero.");
   chk_seq_stop: assert property (engaged_w && !transfer_o && state_reg == DDSPA_ST_RUN && ram_at_final_i
      && at_last_w && !loop_w |=> burst_done_o)
      else $error("Burst did not stop after last profile.");
   chk_ram_only: assert property (!ram_enable_i |-> !seq_engaged_o)
      else $error("Sequencing engaged outside RAM mode.");
   chk_force_ramp: assert property (engaged_w |=> segment_mode_o == DDSPA_RAM_RAMP_UP)
      else $error("Segment mode not forced to ramp-up.");
   chk_pins_ignored: assert property (engaged_w |=> profile_o == seq_prof_reg)
      else $error("Profile pins used while sequencing.");

   cov_burst_done: cover property (state_reg == DDSPA_ST_RUN ##1 burst_done_o);
   cov_loop_wrap: cover property (loop_w && at_last_w && ram_at_final_i && state_reg == DDSPA_ST_RUN);
   cov_auto_clear: cover property (transfer_o && ctrl_reg.auto_clear);
endmodule : ddspa_ctrl

// ### sim/ddspa_host_model.sv
// Host controller model: drives the register-transfer strobe pin.
// Assumes the bench calls its task from one process at a time.
`timescale 1ns/1ps
module ddspa_host_model (
   input wire logic clock_i,
   output logic update_pin_o
);
   initial update_pin_o = 1'b0;

   task automatic strobe();
      @(negedge clock_i);
      update_pin_o = 1'b1;
      repeat (6) @(negedge clock_i);
      update_pin_o = 1'b0;
      repeat (8) @(negedge clock_i);
   endtask : strobe
endmodule : ddspa_host_model

// ### sim/ddspa_ctrl_tb.sv
// Self-checking bench for the profile, phase and amplitude control block.
// Assumes a 40 MHz clock and the host model driving the strobe pin.
`timescale 1ns/1ps
module ddspa_ctrl_tb;
   import ddspa_pkg::*;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic update_pin, key_pin = 1'b0, ram_en = 1'b0, at_final = 1'b0;
   logic [1:0] prof_pin = 2'h0;
   ddspa_ctrl_t ctrl = DDSPA_CTRL_RESET;
   ddspa_amp_t amp = DDSPA_AMP_RESET;
   logic [31:0] fw = 32'h00000000;
   logic [13:0] poff = 14'h0000, sample = 14'h0000;
   logic [2:0] seg_mode = 3'h4;
   logic sync_clk, xfer, engaged, restart, done, sync_prev = 1'b0;
   logic [13:0] phase, scale, ampl;
   logic [1:0] profile;
   logic [2:0] seg_out;
   int err_total = 0, n_checks = 0, xfer_cnt = 0, sync_rises = 0, restart_cnt = 0;

   always #12.5 clock_i = ~clock_i;

   ddspa_host_model u_host (.clock_i(clock_i), .update_pin_o(update_pin));

   ddspa_ctrl u_ddspa_ctrl (
      .clock_i(clock_i), .reset_i(reset_i), .update_pin_i(update_pin), .keying_input_pin_i(key_pin),
      .profile_pin_i(prof_pin), .ctrl_i(ctrl), .amp_i(amp), .freq_word_i(fw), .phase_offset_i(poff),
      .ram_enable_i(ram_en), .ram_segment_mode_i(seg_mode), .ram_at_final_i(at_final),
      .core_sample_i(sample), .sync_clk_o(sync_clk), .transfer_o(xfer), .phase_o(phase),
      .profile_o(profile), .segment_mode_o(seg_out), .seq_engaged_o(engaged),
      .sweep_restart_o(restart), .burst_done_o(done), .scale_factor_o(scale), .amplitude_o(ampl)
   );

   always @(posedge clock_i) begin
      if (xfer === 1'b1) xfer_cnt++;
      if (restart === 1'b1) restart_cnt++;
      if (sync_clk === 1'b1 && sync_prev === 1'b0) sync_rises++;
      sync_prev = sync_clk;
   end

   task automatic check(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check

   task automatic give_verdict();
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   task automatic strobe();
      int c;
      c = xfer_cnt;
      u_host.strobe();
      check(xfer_cnt == c + 1, "held strobe gave other than one transfer");
   endtask : strobe

   task automatic pulse_final();
      at_final = 1'b1;
      @(negedge clock_i);
      at_final = 1'b0;
   endtask : pulse_final

   task automatic t_reset();
      int s0;
      check(profile === 2'h0 && scale === 14'h0000 && xfer === 1'b0, "outputs not cleared by reset");
      sample = 14'h1234;
      repeat (2) @(negedge clock_i);
      check(ampl === 14'h1234, "keying not bypassed after reset");
      s0 = sync_rises;
      repeat (40) @(negedge clock_i);
      check(sync_rises - s0 == 10, "divided clock not a quarter rate");
   endtask : t_reset

   task automatic t_seq();
      int last, e, r;
      ram_en = 1'b1;
      prof_pin = 2'h3;
      for (int code = 1; code < 7; code++) begin
         ctrl = DDSPA_CTRL_RESET;
         ctrl.seq_mode = 3'(code);
         strobe();
         last = (code > 3) ? code - 3 : code;
         check(engaged === 1'b1 && seg_out === DDSPA_RAM_RAMP_UP && profile === 2'h0, "burst start");
         for (int p = 1; p <= last + 1; p++) begin
            r = restart_cnt;
            pulse_final();
            repeat (3) @(negedge clock_i);
            e = (p > last) ? 0 : p;
            check(restart_cnt == r + ((code > 3 || p <= last) ? 1 : 0), "sweep restart pulse wrong");
            if (code > 3 || p <= last) check(profile === 2'(e), "wrong profile after final address");
         end
         check(done === ~ctrl.seq_mode[2], "burst end state wrong");
      end
      ctrl.seq_mode = 3'h1;
      strobe();
      check(done === 1'b0 && profile === 2'h0, "second strobe did not restart burst");
      ctrl.seq_mode = 3'h7;
      strobe();
      check(engaged === 1'b0 && seg_out === 3'h4, "invalid code engaged sequencing");
      ctrl.seq_mode = 3'h1;
      ram_en = 1'b0;
      strobe();
      check(engaged === 1'b0, "sequencing engaged without RAM mode");
   endtask : t_seq

   task automatic t_phase();
      logic [13:0] ph0;
      ctrl = DDSPA_CTRL_RESET;
      ctrl.continuous_clear = 1'b1;
      poff = 14'h0155;
      strobe();
      repeat (3) @(negedge clock_i);
      check(phase === 14'h0155, "held accumulator plus offset wrong");
      fw = 32'h00040000;
      ctrl.continuous_clear = 1'b0;
      strobe();
      ph0 = phase;
      @(negedge clock_i);
      check(phase === ph0 + 14'h0001, "accumulator not running");
      ctrl.auto_clear = 1'b1;
      for (int i = 0; i < 2; i++) begin
         repeat (40) @(negedge clock_i);
         strobe();
         check(phase - poff < 14'h0014, "accumulator not cleared on strobe");
      end
   endtask : t_phase

   task automatic t_ext_key();
      ctrl = DDSPA_CTRL_RESET;
      ctrl.keying_enable = 1'b1;
      amp = DDSPA_AMP_RESET;
      amp.amplitude_scale_register = 14'h2000;
      sample = 14'h3FFF;
      strobe();
      check(scale === 14'h2000 && ampl === 14'h1FFF, "external scaling wrong");
      amp.amplitude_scale_register = 14'h0000;
      repeat (8) @(negedge clock_i);
      check(scale === 14'h2000, "scale changed without strobe");
      strobe();
      check(ampl === 14'h0000, "zero scale not zero output");
      ctrl.keying_enable = 1'b0;
      ctrl.internal_keying = 1'b1;
      strobe();
      check(ampl === 14'h3FFF, "disabled keying not bypassed");
   endtask : t_ext_key

   task automatic wait_step(output int n);
      logic [13:0] v;
      v = scale;
      n = 0;
      while (scale === v && n < 20) begin
         @(negedge clock_i);
         n++;
      end
   endtask : wait_step

   task automatic t_auto_key();
      int n;
      logic [13:0] v0;
      key_pin = 1'b1;
      ctrl = DDSPA_CTRL_RESET;
      ctrl.keying_enable = 1'b1;
      ctrl.internal_keying = 1'b1;
      amp = DDSPA_AMP_RESET;
      amp.amplitude_ramp_rate = 8'h03;
      for (int s = 0; s < 4; s++) begin
         amp.amplitude_limit_word = {2'(s), 14'h3FFF};
         strobe();
         wait_step(n);
         v0 = scale;
         wait_step(n);
         check(scale - v0 === 14'(14'h0001 << s) && n == 3, "auto step size or rate wrong");
      end
      key_pin = 1'b0;
      repeat (300) @(negedge clock_i);
      check(scale === 14'h0000, "ramp down did not stop at zero");
      amp.amplitude_limit_word = 16'hC011;
      ctrl.load_keying_timer = 1'b1;
      strobe();
      key_pin = 1'b1;
      repeat (100) @(negedge clock_i);
      check(scale === 14'h0011, "ramp up did not stop at limit");
   endtask : t_auto_key

   initial begin
      repeat (4) @(negedge clock_i);
      reset_i = 1'b0;
      t_reset();
      t_seq();
      t_phase();
      t_ext_key();
      t_auto_key();
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
endmodule : ddspa_ctrl_tb
